// ---- axis_averager.sv ----
// Accumulator that averages 32 raw readings of one axis
`timescale 1ns/1ps
`default_nettype none
module axis_averager (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic add,
  // Data
  input wire logic [rate_tilt_pkg::AXIS_W-1:0] raw,
  output logic [rate_tilt_pkg::AXIS_W-1:0] avg
);

  logic signed [rate_tilt_pkg::SUM_W-1:0] sum;
  logic signed [rate_tilt_pkg::SUM_W-1:0] raw_ext;

  assign raw_ext = rate_tilt_pkg::SUM_W'($signed(raw));

  // Running sum, cleared at sample start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum <= '0;
    end else if (clear) begin
      sum <= '0;
    end else if (add) begin
      sum <= sum + raw_ext;
    end
  end

  // Divide by 32
  assign avg = sum[rate_tilt_pkg::SUM_W-1:rate_tilt_pkg::AVG_SHIFT];

endmodule
`default_nettype wire

// ---- rate_tilt_debounce.sv ----
// Sample cadence, 32-reading averaging and orientation debounce
`timescale 1ns/1ps
`default_nettype none
module rate_tilt_debounce #(
  parameter int PER_120SPS = rate_tilt_pkg::CYC_120SPS,
  parameter int PER_64SPS = rate_tilt_pkg::CYC_64SPS,
  parameter int PER_32SPS = rate_tilt_pkg::CYC_32SPS,
  parameter int PER_16SPS = rate_tilt_pkg::CYC_16SPS,
  parameter int PER_8SPS = rate_tilt_pkg::CYC_8SPS,
  parameter int PER_4SPS = rate_tilt_pkg::CYC_4SPS,
  parameter int PER_2SPS = rate_tilt_pkg::CYC_2SPS,
  parameter int PER_1SPS = rate_tilt_pkg::CYC_1SPS
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Sample-rate register write port
  input wire logic RATE_WR_EN,
  input wire logic [7:0] RATE_WR_DATA,
  output logic [7:0] SAMPLE_RATE_REG,
  // Operating state
  input wire logic AUTO_WAKE,
  // Raw sensing-cell readings
  input wire logic RAW_VALID,
  input wire logic [5:0] RAW_X,
  input wire logic [5:0] RAW_Y,
  input wire logic [5:0] RAW_Z,
  // Averaged axis outputs
  output logic [5:0] X_AXIS_OUT,
  output logic [5:0] Y_AXIS_OUT,
  output logic [5:0] Z_AXIS_OUT,
  // Orientation status and sample flags
  output logic [2:0] ORIENT_STATUS,
  output logic SAMPLE_DONE,
  output logic MEAS_REQ,
  output logic TAP_MODE
);

  typedef enum logic [1:0] {IDLE, COLLECT, LOAD, ORIENT} seq_t;

  localparam int PW = rate_tilt_pkg::PERIOD_W;

  seq_t state;
  logic [PW-1:0] rate_cnt;
  logic [PW-1:0] period;
  logic [PW-1:0] last_period;
  logic tick;
  logic [4:0] reading_cnt;
  logic avg_clear;
  logic avg_add;
  logic [5:0] avg_x;
  logic [5:0] avg_y;
  logic [5:0] avg_z;
  logic [2:0] active_rate_sel;
  logic [1:0] wake_rate_sel;
  logic [2:0] orient_debounce_sel;
  logic [2:0] candidate;
  logic [3:0] agree_cnt;
  logic [3:0] need_cnt;
  logic [3:0] next_agree;
  logic [2:0] new_orient;
  logic signed [6:0] sx;
  logic signed [6:0] sy;
  logic [6:0] mag_x;
  logic [6:0] mag_y;

  // Sample-rate register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SAMPLE_RATE_REG <= rate_tilt_pkg::SAMPLE_RATE_RESET;
    end else if (RATE_WR_EN) begin
      SAMPLE_RATE_REG <= RATE_WR_DATA;
    end
  end

  // Field split
  assign orient_debounce_sel =
    SAMPLE_RATE_REG[rate_tilt_pkg::DEBOUNCE_MSB:rate_tilt_pkg::DEBOUNCE_LSB];
  assign wake_rate_sel =
    SAMPLE_RATE_REG[rate_tilt_pkg::WAKE_MSB:rate_tilt_pkg::WAKE_LSB];
  assign active_rate_sel =
    SAMPLE_RATE_REG[rate_tilt_pkg::ACTIVE_MSB:rate_tilt_pkg::ACTIVE_LSB];

  // Governing sample period
  always_comb begin
    period = PW'(PER_1SPS);
    if (AUTO_WAKE) begin
      unique case (wake_rate_sel)
        rate_tilt_pkg::WAKE_32SPS: period = PW'(PER_32SPS);
        rate_tilt_pkg::WAKE_16SPS: period = PW'(PER_16SPS);
        rate_tilt_pkg::WAKE_8SPS: period = PW'(PER_8SPS);
        rate_tilt_pkg::WAKE_1SPS: period = PW'(PER_1SPS);
      endcase
    end else begin
      unique case (active_rate_sel)
        rate_tilt_pkg::ACTIVE_120SPS_TAP: period = PW'(PER_120SPS);
        rate_tilt_pkg::ACTIVE_64SPS: period = PW'(PER_64SPS);
        rate_tilt_pkg::ACTIVE_32SPS: period = PW'(PER_32SPS);
        rate_tilt_pkg::ACTIVE_16SPS: period = PW'(PER_16SPS);
        rate_tilt_pkg::ACTIVE_8SPS: period = PW'(PER_8SPS);
        rate_tilt_pkg::ACTIVE_4SPS: period = PW'(PER_4SPS);
        rate_tilt_pkg::ACTIVE_2SPS: period = PW'(PER_2SPS);
        rate_tilt_pkg::ACTIVE_1SPS: period = PW'(PER_1SPS);
      endcase
    end
  end

  // Period timer, restarted when the governing period changes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rate_cnt <= '0;
      last_period <= '0;
      tick <= 1'b0;
    end else begin
      last_period <= period;
      if (period != last_period) begin
        rate_cnt <= '0;
        tick <= 1'b0;
      end else if (rate_cnt >= period - PW'(1)) begin
        rate_cnt <= '0;
        tick <= 1'b1;
      end else begin
        rate_cnt <= rate_cnt + PW'(1);
        tick <= 1'b0;
      end
    end
  end

  // Fast tap sampling flag
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      TAP_MODE <= 1'b0;
    end else begin
      TAP_MODE <= !AUTO_WAKE &&
        (active_rate_sel == rate_tilt_pkg::ACTIVE_120SPS_TAP);
    end
  end

  // Sample sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          if (tick) begin
            state <= COLLECT;
          end
        end
        COLLECT: begin
          if (RAW_VALID && reading_cnt == rate_tilt_pkg::AVG_LAST) begin
            state <= LOAD;
          end
        end
        LOAD: begin
          state <= ORIENT;
        end
        ORIENT: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // Reading counter
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      reading_cnt <= '0;
    end else if (state == IDLE) begin
      reading_cnt <= '0;
    end else if (avg_add) begin
      reading_cnt <= reading_cnt + 5'h1;
    end
  end

  // Measurement request while collecting
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      MEAS_REQ <= 1'b0;
    end else if (state == IDLE && tick) begin
      MEAS_REQ <= 1'b1;
    end else if (state == COLLECT && RAW_VALID &&
                 reading_cnt == rate_tilt_pkg::AVG_LAST) begin
      MEAS_REQ <= 1'b0;
    end
  end

  assign avg_clear = (state == IDLE) && tick;
  assign avg_add = (state == COLLECT) && RAW_VALID;

  axis_averager u_avg_x (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(avg_clear),
    .add(avg_add),
    .raw(RAW_X),
    .avg(avg_x)
  );

  axis_averager u_avg_y (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(avg_clear),
    .add(avg_add),
    .raw(RAW_Y),
    .avg(avg_y)
  );

  axis_averager u_avg_z (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(avg_clear),
    .add(avg_add),
    .raw(RAW_Z),
    .avg(avg_z)
  );

  // Axis output registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      X_AXIS_OUT <= '0;
      Y_AXIS_OUT <= '0;
      Z_AXIS_OUT <= '0;
    end else if (state == LOAD) begin
      X_AXIS_OUT <= avg_x;
      Y_AXIS_OUT <= avg_y;
      Z_AXIS_OUT <= avg_z;
    end
  end

  // Orientation of the newest sample
  assign sx = 7'($signed(X_AXIS_OUT));
  assign sy = 7'($signed(Y_AXIS_OUT));
  assign mag_x = sx[6] ? 7'(-sx) : 7'(sx);
  assign mag_y = sy[6] ? 7'(-sy) : 7'(sy);

  always_comb begin
    new_orient = rate_tilt_pkg::ORIENT_UNKNOWN;
    if (mag_x == 7'h00 && mag_y == 7'h00) begin
      new_orient = rate_tilt_pkg::ORIENT_UNKNOWN;
    end else if (mag_x >= mag_y) begin
      new_orient = sx[6] ? rate_tilt_pkg::ORIENT_X_NEG
                         : rate_tilt_pkg::ORIENT_X_POS;
    end else begin
      new_orient = sy[6] ? rate_tilt_pkg::ORIENT_Y_NEG
                         : rate_tilt_pkg::ORIENT_Y_POS;
    end
  end

  // Agreeing samples needed
  assign need_cnt = {1'b0, orient_debounce_sel} + 4'h1;
  assign next_agree = agree_cnt + 4'h1;

  // Debounce, one step per sample at the governing rate
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      candidate <= rate_tilt_pkg::ORIENT_UNKNOWN;
      agree_cnt <= '0;
      ORIENT_STATUS <= rate_tilt_pkg::ORIENT_UNKNOWN;
    end else if (state == ORIENT) begin
      if (orient_debounce_sel == 3'h0) begin
        candidate <= new_orient;
        agree_cnt <= 4'h1;
        ORIENT_STATUS <= new_orient;
      end else if (new_orient != candidate) begin
        candidate <= new_orient;
        agree_cnt <= 4'h1;
      end else if (next_agree >= need_cnt) begin
        agree_cnt <= need_cnt;
        ORIENT_STATUS <= candidate;
      end else begin
        agree_cnt <= next_agree;
      end
    end
  end

  // Sample completion pulse
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SAMPLE_DONE <= 1'b0;
    end else begin
      SAMPLE_DONE <= (state == ORIENT);
    end
  end

endmodule
`default_nettype wire

// ---- rate_tilt_debounce_properties.sv ----
// Port checker for the sample-rate and orientation debounce block
`timescale 1ns/1ps
`default_nettype none
module rate_tilt_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Rate register
  input wire logic RATE_WR_EN,
  input wire logic [7:0] RATE_WR_DATA,
  input wire logic [7:0] SAMPLE_RATE_REG,
  input wire logic AUTO_WAKE,
  // Results
  input wire logic [5:0] X_AXIS_OUT,
  input wire logic [2:0] ORIENT_STATUS,
  input wire logic SAMPLE_DONE,
  input wire logic MEAS_REQ,
  input wire logic TAP_MODE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  property p_wr;
    RATE_WR_EN |=> SAMPLE_RATE_REG == $past(RATE_WR_DATA);
  endproperty
  a_wr: assert property (p_wr)
    else $error("rate write not taken");

  property p_hold;
    !RATE_WR_EN |=> $stable(SAMPLE_RATE_REG);
  endproperty
  a_hold: assert property (p_hold)
    else $error("rate register moved");

  property p_tap;
    !$past(RST) |->
      TAP_MODE == $past(!AUTO_WAKE && SAMPLE_RATE_REG[2:0] == 3'h0);
  endproperty
  a_tap: assert property (p_tap)
    else $error("tap mode wrong");

  property p_pulse;
    SAMPLE_DONE |=> !SAMPLE_DONE;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done longer than a cycle");

  property p_done;
    $fell(MEAS_REQ) |-> ##2 SAMPLE_DONE;
  endproperty
  a_done: assert property (p_done)
    else $error("done late after collection");

  property p_cause;
    SAMPLE_DONE |-> $past(MEAS_REQ, 3) && !$past(MEAS_REQ, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("done without collection");

  property p_axes;
    $changed(X_AXIS_OUT) |-> !$past(MEAS_REQ) && $past(MEAS_REQ, 2);
  endproperty
  a_axes: assert property (p_axes)
    else $error("axis output moved off sample");

  property p_orient;
    $changed(ORIENT_STATUS) |-> SAMPLE_DONE;
  endproperty
  a_orient: assert property (p_orient)
    else $error("orientation moved off sample");
endmodule

bind rate_tilt_debounce rate_tilt_checker i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .RATE_WR_EN(RATE_WR_EN),
  .RATE_WR_DATA(RATE_WR_DATA), .SAMPLE_RATE_REG(SAMPLE_RATE_REG),
  .AUTO_WAKE(AUTO_WAKE), .X_AXIS_OUT(X_AXIS_OUT),
  .ORIENT_STATUS(ORIENT_STATUS), .SAMPLE_DONE(SAMPLE_DONE),
  .MEAS_REQ(MEAS_REQ), .TAP_MODE(TAP_MODE)
);
`default_nettype wire

// ---- rate_tilt_debounce_tb_top.sv ----
// Self-checking bench for the sample-rate and orientation debounce block
`timescale 1ns/1ps
`default_nettype none
module rate_tilt_debounce_tb_top;
  localparam int P [8] = '{100, 120, 140, 160, 180, 200, 220, 240};
  localparam int W [4] = '{140, 160, 180, 240};
  logic clk, rst, wr_en, auto_wake, raw_valid;
  logic ph = 1'b0;
  logic gap = 1'b0;
  logic [7:0] wr_data, rate_q;
  logic [5:0] xa, xb, ya, yb, raw_x, raw_y, raw_z, xo, yo, zo;
  logic [2:0] orient;
  logic done, meas, tap;
  int fails, checked;

  assign raw_x = ph ? xa : xb;
  assign raw_y = ph ? ya : yb;
  assign raw_z = ph ? xb : xa;
  // Readings on every other cycle while gap is set
  assign raw_valid = gap ? ph : 1'b1;

  rate_tilt_debounce #(.PER_120SPS(P[0]), .PER_64SPS(P[1]),
    .PER_32SPS(P[2]), .PER_16SPS(P[3]), .PER_8SPS(P[4]), .PER_4SPS(P[5]),
    .PER_2SPS(P[6]), .PER_1SPS(P[7])) i_dut (
    .CORE_CLK(clk), .RST(rst), .RATE_WR_EN(wr_en), .RATE_WR_DATA(wr_data),
    .SAMPLE_RATE_REG(rate_q), .AUTO_WAKE(auto_wake), .RAW_VALID(raw_valid),
    .RAW_X(raw_x), .RAW_Y(raw_y), .RAW_Z(raw_z), .X_AXIS_OUT(xo),
    .Y_AXIS_OUT(yo), .Z_AXIS_OUT(zo), .ORIENT_STATUS(orient),
    .SAMPLE_DONE(done), .MEAS_REQ(meas), .TAP_MODE(tap)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Alternate readings so each average taken while gap is clear mixes two values
  always @(posedge clk) begin
    #1;
    ph = ~ph;
  end

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    fails++;
    $display("BAD %s expected event seen none", what);
    close_out();
  endtask

  task automatic wr(input logic [7:0] d);
    wr_data = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    check("rate register", d, rate_q);
  endtask

  task automatic next_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) timeout("sample done");
    end while (done !== 1'b1);
  endtask

  task automatic rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = meas;
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) timeout("sample start");
    end while (!(prev === 1'b0 && meas === 1'b1));
  endtask

  task automatic t_rates();
    int n;
    for (int c = 0; c < 12; c++) begin
      auto_wake = (c >= 8);
      wr({3'h0, c[1:0], (c >= 8) ? 3'h7 : c[2:0]});
      rise(n);
      rise(n);
      check("period", 8'(c < 8 ? P[c] : W[c - 8]), 8'(n));
      check("tap mode", 8'(c == 0), {7'h0, tap});
    end
    $display("rate test over");
  endtask

  task automatic t_avg();
    logic [5:0] ex_x [3] = '{6'h01, 6'h3e, 6'h05};
    logic [5:0] ex_y [3] = '{6'h00, 6'h00, 6'h01};
    logic [5:0] ex_z [3] = '{6'h01, 6'h3e, 6'h3e};
    logic [2:0] ex_o [3] = '{3'h1, 3'h2, 3'h1};
    wr(8'h00);
    auto_wake = 1'b0;
    for (int k = 0; k < 3; k++) begin
      gap = (k == 2);
      xa = (k == 1) ? 6'h3b : 6'h05;
      xb = (k == 1) ? 6'h02 : 6'h3e;
      ya = 6'h01;
      yb = 6'h00;
      next_done();
      next_done();
      check("x average", {2'b0, ex_x[k]}, {2'b0, xo});
      check("y average", {2'b0, ex_y[k]}, {2'b0, yo});
      check("z average", {2'b0, ex_z[k]}, {2'b0, zo});
      check("orientation", {5'b0, ex_o[k]}, {5'b0, orient});
    end
    gap = 1'b0;
    $display("average test over");
  endtask

  task automatic t_reset();
    int n;
    auto_wake = 1'b0;
    rst = 1'b1;
    @(posedge clk);
    #1;
    check("mid reset rate register", 8'h00, rate_q);
    check("mid reset orientation", 8'h00, {5'b0, orient});
    check("mid reset x axis", 8'h00, {2'b0, xo});
    rst = 1'b0;
    rise(n);
    rise(n);
    check("period after reset", 8'(P[0]), 8'(n));
    check("tap after mid reset", 8'h01, {7'h0, tap});
    $display("reset test over");
  endtask

  task automatic set_dir(input logic pos);
    xa = pos ? 6'h0a : 6'h36;
    xb = xa;
    ya = 6'h00;
    yb = 6'h00;
  endtask

  task automatic t_debounce();
    int n;
    for (int f = 0; f < 8; f++) begin
      auto_wake = f[0];
      wr({f[2:0], 5'h00});
      set_dir(1'b1);
      repeat (f + 2) next_done();
      check("settled orientation", 8'h01, {5'b0, orient});
      set_dir(1'b0);
      if (f > 0) begin
        repeat (f) next_done();
        check("held orientation", 8'h01, {5'b0, orient});
        set_dir(1'b1);
        next_done();
        set_dir(1'b0);
      end
      n = 0;
      do begin
        next_done();
        n++;
      end while (orient !== 3'h2 && n < 12);
      check("samples to change", 8'(f + 1), 8'(n));
    end
    $display("debounce test over");
  endtask

  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    wr_data = 8'h00;
    auto_wake = 1'b0;
    set_dir(1'b1);
    fails = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #1;
    check("reset rate register", 8'h00, rate_q);
    check("reset orientation", 8'h00, {5'b0, orient});
    rst = 1'b0;
    @(posedge clk);
    #1;
    check("tap after reset", 8'h01, {7'h0, tap});
    t_rates();
    t_avg();
    t_debounce();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire

// ---- rate_tilt_pkg.sv ----
// Constants shared by the sample-rate and orientation debounce block
package rate_tilt_pkg;

  // Sample-rate register layout and reset value
  localparam int RATE_REG_W = 8;
  localparam int DEBOUNCE_MSB = 7;
  localparam int DEBOUNCE_LSB = 5;
  localparam int WAKE_MSB = 4;
  localparam int WAKE_LSB = 3;
  localparam int ACTIVE_MSB = 2;
  localparam int ACTIVE_LSB = 0;
  localparam logic [7:0] SAMPLE_RATE_RESET = 8'h00;

  // Address of the orientation status register
  localparam logic [7:0] ORIENT_STATUS_ADDR = 8'h03;

  // Active-rate codes
  localparam logic [2:0] ACTIVE_120SPS_TAP = 3'h0;
  localparam logic [2:0] ACTIVE_64SPS = 3'h1;
  localparam logic [2:0] ACTIVE_32SPS = 3'h2;
  localparam logic [2:0] ACTIVE_16SPS = 3'h3;
  localparam logic [2:0] ACTIVE_8SPS = 3'h4;
  localparam logic [2:0] ACTIVE_4SPS = 3'h5;
  localparam logic [2:0] ACTIVE_2SPS = 3'h6;
  localparam logic [2:0] ACTIVE_1SPS = 3'h7;

  // Wake-rate codes
  localparam logic [1:0] WAKE_32SPS = 2'h0;
  localparam logic [1:0] WAKE_16SPS = 2'h1;
  localparam logic [1:0] WAKE_8SPS = 2'h2;
  localparam logic [1:0] WAKE_1SPS = 2'h3;

  // Sample periods in milliseconds
  localparam real CLK_KHZ = 25000.0;
  localparam real T_120SPS_MS = 8.36;
  localparam real T_64SPS_MS = 15.625;
  localparam real T_32SPS_MS = 31.25;
  localparam real T_16SPS_MS = 62.5;
  localparam real T_8SPS_MS = 125.0;
  localparam real T_4SPS_MS = 250.0;
  localparam real T_2SPS_MS = 500.0;
  localparam real T_1SPS_MS = 1000.0;

  // Sample periods in clock cycles
  localparam int CYC_120SPS = $rtoi(T_120SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_64SPS = $rtoi(T_64SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_32SPS = $rtoi(T_32SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_16SPS = $rtoi(T_16SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_8SPS = $rtoi(T_8SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_4SPS = $rtoi(T_4SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_2SPS = $rtoi(T_2SPS_MS * CLK_KHZ + 0.5);
  localparam int CYC_1SPS = $rtoi(T_1SPS_MS * CLK_KHZ + 0.5);
  localparam int PERIOD_W = 25;

  // Averaging
  localparam int AXIS_W = 6;
  localparam int AVG_SHIFT = 5;
  localparam int SUM_W = AXIS_W + AVG_SHIFT;
  localparam logic [4:0] AVG_LAST = 5'h1f;

  // Orientation codes
  localparam logic [2:0] ORIENT_UNKNOWN = 3'h0;
  localparam logic [2:0] ORIENT_X_POS = 3'h1;
  localparam logic [2:0] ORIENT_X_NEG = 3'h2;
  localparam logic [2:0] ORIENT_Y_NEG = 3'h5;
  localparam logic [2:0] ORIENT_Y_POS = 3'h6;

endpackage
